// File: rtl/ssio_top.sv
// Behaviour
// (R01) Sync mode active when enabled and pin gating off, or gating on with bit2 low.
// (R02) Sample parameter bit 2 at the rising data strobe for the next output event.
// (R03) With multiplexing, sync enable and pin gating set, bit 2 leaves multiplexing.
// (R04) Trigger when a data-exchange address is below the previous good one.
// (R05) At trigger, update outputs and strobe only if data arrived last cycle.
// (R06) Sample inputs at every trigger, regardless of received output data.
// (R07) Lowest-address slave in sync mode delays its outputs one full cycle.
// (R08) Master builds its output image once per cycle and keeps it fixed.
// (R09) Master polls all A slaves in one cycle, all B slaves in the other.
// (R10) Inputs sampled at trigger go back in the immediate response.
// (R11) First exchange after port enable runs normally, then repeats at trigger.
// (R12) Lowest slave with gating loses one value on disable, repeats one on enable.
// (R13) Three consecutive own-address exchanges suspend sync operation.
// (R14) An exchange to another address resumes sync, first call handled normally.
// (R15) Sync mode still produces the data strobe with normal sampling timing.
// (R16) Extended address mode uses info bit 3 to pick A or B slave.
// (R17) Extended mode plus four-output flag makes info bit 2 a bank select.
// (R18) Banked outputs change only on bit 2 clear after a bit 2 set call.
// (R19) The bit 2 toggle detector starts at zero after reset.
// (R20) Banked mode samples and returns inputs on every call.
// (R21) Bit 2 set stages call bits 0 and 1 without touching pins.
// (R22) Bit 2 clear drives bits 0,1 to outputs 2,3 and staging to outputs 0,1.
// (R23) Exchange block flag set at reset, cleared by first parameter call.
// (R24) Previous address invalid after reset, so first exchange never triggers.
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module ssio_top
  import ssio_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic [7:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output      logic [31:0]            avs_readdata,
  output      logic                   avs_waitrequest,
  input  wire logic                   call_valid,
  input  wire ssio_call_t             call,
  input  wire logic [SSIO_DATA_W-1:0] data_in,
  input  wire logic                   param_port_bit2,
  output      logic                   resp_valid,
  output      logic [SSIO_DATA_W-1:0] resp_data,
  output      logic [SSIO_DATA_W-1:0] out_pin,
  output      logic                   data_strobe,
  output      logic                   param_mux_excl_bit2
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Merge a bus write into a register under its byte enables.
  function automatic logic [31:0] ssio_merge(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0]  be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : ssio_merge

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [SSIO_DATA_W:0]   pin_meta;
  logic [SSIO_DATA_W:0]   pin_sync;
  logic [SSIO_DATA_W-1:0] data_in_s;
  logic                   pbit2_s;

  // The data and parameter pins are asynchronous; only stage two is read.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {param_port_bit2, data_in};
      pin_sync <= pin_meta;
    end
  end

  assign data_in_s = pin_sync[SSIO_DATA_W-1:0];
  assign pbit2_s   = pin_sync[SSIO_DATA_W];

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [31:0]            ctrl;
  logic [31:0]            own_reg;
  logic                   sync_en;
  logic                   pin_gated_sync_flag;
  logic                   ext_addr;
  logic                   ext_addr_four_out_flag;
  logic                   param_mux_en;
  logic [SSIO_ADDR_W-1:0] own_addr;
  logic                   own_ab;
  logic                   wr_go;

  assign sync_en                = ctrl[SSIO_CTRL_SYNC_EN];
  assign pin_gated_sync_flag    = ctrl[SSIO_CTRL_PIN_GATED];
  assign ext_addr               = ctrl[SSIO_CTRL_EXT_ADDR];
  assign ext_addr_four_out_flag = ctrl[SSIO_CTRL_FOUR_OUT];
  assign param_mux_en           = ctrl[SSIO_CTRL_PARAM_MUX];
  assign own_addr               = own_reg[SSIO_OWN_ADDR_LSB +: SSIO_ADDR_W];
  assign own_ab                 = own_reg[SSIO_OWN_AB_BIT];

  // A write lands only at the edge where waitrequest is seen low.
  assign wr_go = avs_write && !avs_waitrequest;

  // Software writes to the two writable words; status and holes ignore it.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl    <= SSIO_CTRL_RESET;
      own_reg <= SSIO_OWN_RESET;
    end else if (wr_go) begin
      if (avs_address == SSIO_REG_CTRL) begin
        ctrl <= ssio_merge(ctrl, avs_writedata, avs_byteenable);
      end else if (avs_address == SSIO_REG_OWN) begin
        own_reg <= ssio_merge(own_reg, avs_writedata, avs_byteenable);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Call decode
  // ----------------------------------------------------------------------
  ssio_mode_t             mode;
  ssio_mode_t             next_mode;
  logic                   dexg_ok;
  logic                   addr_own;
  logic                   own_take;
  logic                   own_third;
  logic [1:0]             own_cnt;
  logic                   trig;
  logic                   word_valid;
  logic [SSIO_DATA_W-1:0] word;

  // Exchange calls are ignored entirely while the port is still blocked.
  assign dexg_ok   = call_valid && call.dexg && call.ok && (mode != SSIO_BLOCKED); // R23
  assign addr_own  = (call.addr == own_addr);
  assign own_take  = dexg_ok && addr_own && (!ext_addr || (call.info[3] == own_ab)); // R16
  assign own_third = dexg_ok && addr_own && (own_cnt == SSIO_OWN_LIMIT);

  ssio_trigger u_trig (
    .ref_clk (ref_clk),
    .rst     (rst),
    .dexg_ok (dexg_ok),
    .addr    (call.addr),
    .trigger (trig)
  );

  ssio_bank u_bank (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .take       (own_take),
    .ext_addr   (ext_addr),
    .four_out   (ext_addr_four_out_flag),
    .info       (call.info),
    .cur_out    (out_pin),
    .word_valid (word_valid),
    .word       (word)
  );

  // Consecutive calls to our own address; any other address restarts it.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      own_cnt <= 2'h0;
    end else if (dexg_ok) begin
      if (!addr_own) begin
        own_cnt <= 2'h0;
      end else if (own_cnt != SSIO_OWN_LIMIT) begin
        own_cnt <= own_cnt + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Mode sequencing
  // ----------------------------------------------------------------------
  logic pbit2_sample;
  logic sync_active;
  logic sync_run;

  // The latched bit 2, not the live pin, gates the mode.
  assign sync_active = sync_en && (!pin_gated_sync_flag || !pbit2_sample); // R01
  assign sync_run    = sync_active && (mode == SSIO_SYNC);

  // Blocked, then one normal call, then synchronous; suspension loops back.
  always_comb begin
    next_mode = mode;
    case (mode)
      SSIO_BLOCKED: begin
        if (call_valid && call.wpar && call.ok) begin
          next_mode = SSIO_FIRST; // R23
        end
      end
      SSIO_FIRST: begin
        if (own_take && sync_active) begin
          next_mode = SSIO_SYNC; // R11
        end
      end
      SSIO_SYNC: begin
        if (own_third) begin
          next_mode = SSIO_SUSP; // R13
        end
      end
      SSIO_SUSP: begin
        if (dexg_ok && !addr_own) begin
          next_mode = SSIO_FIRST; // R14
        end
      end
      default: next_mode = SSIO_BLOCKED;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode <= SSIO_BLOCKED; // R23
    end else begin
      mode <= next_mode;
    end
  end

  // ----------------------------------------------------------------------
  // Output path
  // ----------------------------------------------------------------------
  logic                   armed;
  logic [SSIO_DATA_W-1:0] pending;
  logic                   normal_apply;
  logic                   trig_apply;
  logic                   next_strobe;
  logic [SSIO_DATA_W-1:0] next_out;

  // Outside synchronous running, a released word goes straight to the pins.
  assign normal_apply = word_valid && !sync_run;
  // At a trigger, only an armed word is fired; an empty cycle changes nothing.
  assign trig_apply   = sync_run && trig && armed; // R05
  assign next_strobe  = normal_apply || trig_apply; // R15
  assign next_out     = trig_apply ? pending : word;

  // Arming after firing in the same cycle delays the lowest slave one cycle.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      armed   <= 1'b0;
      pending <= '0;
    end else if (word_valid && sync_active &&
                 (mode == SSIO_SYNC || mode == SSIO_FIRST)) begin
      armed   <= 1'b1; // R07 R11
      pending <= word;
    end else if (trig_apply) begin
      armed <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_pin     <= '0;
      data_strobe <= 1'b0;
    end else begin
      data_strobe <= next_strobe;
      if (next_strobe) begin
        out_pin <= next_out;
      end
    end
  end

  // Bit 2 is caught as the strobe rises; a late pin change shifts one value.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pbit2_sample <= 1'b0;
    end else if (next_strobe && !data_strobe) begin
      pbit2_sample <= pbit2_s; // R02 R12
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      param_mux_excl_bit2 <= 1'b0;
    end else begin
      param_mux_excl_bit2 <= param_mux_en && sync_en && pin_gated_sync_flag; // R03
    end
  end

  // ----------------------------------------------------------------------
  // Input path and response
  // ----------------------------------------------------------------------
  logic [SSIO_DATA_W-1:0] sampled;

  // Sync mode samples only at triggers; otherwise at each own call.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sampled <= '0;
    end else if (sync_run && trig) begin
      sampled <= data_in_s; // R06
    end else if (own_take && !sync_run) begin
      sampled <= data_in_s;
    end
  end

  // Every own call answers, banked or not, with the freshest valid sample.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_data  <= '0;
    end else begin
      resp_valid <= own_take; // R20
      if (own_take) begin
        resp_data <= (sync_run && !trig) ? sampled : data_in_s; // R10
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = SSIO_RD_UNMAPPED;
    if (avs_address == SSIO_REG_CTRL) begin
      rd_mux = ctrl;
    end else if (avs_address == SSIO_REG_OWN) begin
      rd_mux = own_reg;
    end else if (avs_address == SSIO_REG_STATUS) begin
      rd_mux[SSIO_ST_SYNC_ACTIVE] = sync_run;
      rd_mux[SSIO_ST_SUSPENDED]   = (mode == SSIO_SUSP);
      rd_mux[SSIO_ST_BLOCKED]     = (mode == SSIO_BLOCKED);
      rd_mux[SSIO_ST_ARMED]       = armed;
      rd_mux[SSIO_ST_OUT_LSB +: SSIO_DATA_W] = out_pin;
      rd_mux[SSIO_ST_IN_LSB +: SSIO_DATA_W]  = sampled;
      rd_mux[SSIO_ST_PBIT2]       = pbit2_sample;
    end
  end

  // One wait cycle per access keeps the read mux off the bus path.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_mux : 32'h00000000;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_armed_trigger;
    sync_run && trig && armed;
  endsequence

  sequence s_fired(logic [SSIO_DATA_W-1:0] v);
    data_strobe && (out_pin == v);
  endsequence

  armed_fire_a: assert property (s_armed_trigger |=> s_fired($past(pending)))
    else $error("Armed trigger did not fire the pending word."); // R05

  empty_trig_a: assert property (sync_run && trig && !armed |=> !data_strobe)
    else $error("Strobe without data received last cycle."); // R05

  disabled_direct_a: assert property (!sync_en && word_valid |=> s_fired($past(word)))
    else $error("Word not applied at once with sync disabled."); // R01

  pbit2_catch_a: assert property ($rose(data_strobe) |-> pbit2_sample == $past(pbit2_s))
    else $error("Bit 2 not caught at rising strobe."); // R02

  block_ignore_a: assert property (mode == SSIO_BLOCKED |=> !resp_valid && !data_strobe)
    else $error("Exchange answered while blocked."); // R23

  suspend_third_a: assert property (mode == SSIO_SYNC && own_third |=> mode == SSIO_SUSP)
    else $error("Third own call did not suspend."); // R13

  resume_other_a: assert property (mode == SSIO_SUSP && dexg_ok && !addr_own
                                   |=> mode == SSIO_FIRST)
    else $error("Other address did not resume."); // R14

  trig_resp_a: assert property (own_take && sync_run && trig
                                |=> resp_valid && resp_data == $past(data_in_s))
    else $error("Trigger sample not returned at once."); // R10

  first_call_a: assert property (mode == SSIO_FIRST && word_valid |=> data_strobe)
    else $error("First call not processed normally."); // R11

  stage_quiet_a: assert property (own_take && ext_addr && ext_addr_four_out_flag
                                  && call.info[2] |=> !data_strobe && $stable(out_pin))
    else $error("Staging call changed the pins."); // R21

endmodule : ssio_top

// File: shared/ssio_pkg.sv
package ssio_pkg;

  // ----------------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------------
  localparam logic [7:0]  SSIO_REG_CTRL   = 8'h00;
  localparam logic [7:0]  SSIO_REG_STATUS = 8'h04;
  localparam logic [7:0]  SSIO_REG_OWN    = 8'h08;
  localparam logic [31:0] SSIO_CTRL_RESET = 32'h00000000;
  localparam logic [31:0] SSIO_OWN_RESET  = 32'h00000000;
  localparam logic [31:0] SSIO_RD_UNMAPPED = 32'h00000000;

  // Control word bits.
  localparam int SSIO_CTRL_SYNC_EN    = 0;
  localparam int SSIO_CTRL_PIN_GATED  = 1;
  localparam int SSIO_CTRL_EXT_ADDR   = 2;
  localparam int SSIO_CTRL_FOUR_OUT   = 3;
  localparam int SSIO_CTRL_PARAM_MUX  = 4;

  // Own address word: slave address in the low bits, A/B select above.
  localparam int SSIO_OWN_ADDR_LSB    = 0;
  localparam int SSIO_OWN_AB_BIT      = 8;

  // Status word bits.
  localparam int SSIO_ST_SYNC_ACTIVE  = 0;
  localparam int SSIO_ST_SUSPENDED    = 1;
  localparam int SSIO_ST_BLOCKED      = 2;
  localparam int SSIO_ST_ARMED        = 3;
  localparam int SSIO_ST_OUT_LSB      = 4;
  localparam int SSIO_ST_IN_LSB       = 8;
  localparam int SSIO_ST_PBIT2        = 12;

  // Widths and counts.
  localparam int         SSIO_ADDR_W    = 5;
  localparam int         SSIO_DATA_W    = 4;
  localparam logic [1:0] SSIO_OWN_LIMIT = 2'h2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SSIO_BLOCKED = 2'b00,
    SSIO_FIRST   = 2'b01,
    SSIO_SYNC    = 2'b11,
    SSIO_SUSP    = 2'b10
  } ssio_mode_t;

  typedef struct packed {
    logic                   dexg;
    logic                   wpar;
    logic                   ok;
    logic [SSIO_ADDR_W-1:0] addr;
    logic [SSIO_DATA_W-1:0] info;
  } ssio_call_t;

endpackage : ssio_pkg

// File: rtl/ssio_trigger.sv
`timescale 1ns/1ns
module ssio_trigger
  import ssio_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   dexg_ok,
  input  wire logic [SSIO_ADDR_W-1:0] addr,
  output      logic                   trigger
);

  // ----------------------------------------------------------------------
  // Previous address store
  // ----------------------------------------------------------------------
  logic [SSIO_ADDR_W-1:0] prev_addr;
  logic                   prev_valid;

  // A fall in address marks the start of a new polling cycle.
  assign trigger = dexg_ok && prev_valid && (addr < prev_addr); // R04 R24

  // The stored address starts invalid so the first call cannot fire.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_addr  <= '0;
      prev_valid <= 1'b0; // R24
    end else if (dexg_ok) begin
      prev_addr  <= addr;
      prev_valid <= 1'b1;
    end
  end

  no_first_trig_a: assert property (@(posedge ref_clk) disable iff (rst)
    !prev_valid |-> !trigger) else $error("Trigger before any stored address."); // R24

endmodule : ssio_trigger

// File: rtl/ssio_bank.sv
`timescale 1ns/1ns
module ssio_bank
  import ssio_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   take,
  input  wire logic                   ext_addr,
  input  wire logic                   four_out,
  input  wire logic [SSIO_DATA_W-1:0] info,
  input  wire logic [SSIO_DATA_W-1:0] cur_out,
  output      logic                   word_valid,
  output      logic [SSIO_DATA_W-1:0] word
);

  // ----------------------------------------------------------------------
  // Staging and bit-2 toggle detector
  // ----------------------------------------------------------------------
  logic staged_out_bit0;
  logic staged_out_bit1;
  logic last_bit2;
  logic banked;

  assign banked = ext_addr && four_out; // R17

  // Only a falling bit 2 releases a word in banked mode.
  always_comb begin
    if (banked) begin
      word_valid = take && !info[2] && last_bit2; // R18
      word       = {info[1], info[0], staged_out_bit1, staged_out_bit0}; // R22
    end else if (ext_addr) begin
      word_valid = take;
      word       = {cur_out[3], info[2:0]}; // Bit 3 selects A or B, not data.
    end else begin
      word_valid = take;
      word       = info;
    end
  end

  // Bank 1 bits wait here while bit 2 is high; no pin changes meanwhile.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      staged_out_bit0 <= 1'b0;
      staged_out_bit1 <= 1'b0;
      last_bit2       <= 1'b0; // R19
    end else if (take && banked) begin
      last_bit2 <= info[2];
      if (info[2]) begin
        staged_out_bit0 <= info[0]; // R21
        staged_out_bit1 <= info[1]; // R21
      end
    end
  end

endmodule : ssio_bank

// File: sim/ssio_master_model.sv
`timescale 1ns/1ns
module ssio_master_model
  import ssio_pkg::*;
(
  input  wire logic ref_clk,
  output      logic       call_valid,
  output      ssio_call_t call
);
  // Idle bus before the first call.
  initial begin
    call_valid = 1'b0;
    call       = '0;
  end

  // One call per request; the caller keeps one frozen image per cycle.
  // A and B callers can share one cycle; t_bank sends both to address 5.
  task automatic send(input logic d, input logic w, input logic [4:0] a,
                      input logic [3:0] i);
    @(posedge ref_clk);
    call_valid <= 1'b1;
    call       <= '{dexg: d, wpar: w, ok: 1'b1, addr: a, info: i};
    @(posedge ref_clk);
    call_valid <= 1'b0;
    call       <= ~call; // Stale fields must not look valid.
  endtask : send
endmodule : ssio_master_model

// File: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import ssio_pkg::*;
;
  logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, call_valid;
  logic resp_valid, data_strobe, param_mux_excl_bit2, param_port_bit2;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  logic [3:0]  data_in, resp_data, out_pin;
  ssio_call_t  call;
  int          err_count, num_checks, strobes, s0;

  // ----------------------------------------------------------------------
  // Clock, reset and strobe counting
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Strobes are counted so that missing or extra pulses show later.
  always @(posedge ref_clk) if (data_strobe === 1'b1) strobes++;

  ssio_master_model i_master (.ref_clk(ref_clk), .call_valid(call_valid), .call(call));

  ssio_top i_dut (
    .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .call_valid(call_valid), .call(call), .data_in(data_in),
    .param_port_bit2(param_port_bit2), .resp_valid(resp_valid), .resp_data(resp_data),
    .out_pin(out_pin), .data_strobe(data_strobe), .param_mux_excl_bit2(param_mux_excl_bit2)
  );

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_address   <= a;
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // Sends one call and checks the response pulse a moment after it lands.
  task automatic xchg(input logic w, input logic [4:0] a, input logic [3:0] i,
                      input logic exp);
    i_master.send(!w, w, a, i);
    #1;
    chk({31'h0, resp_valid}, {31'h0, exp});
  endtask : xchg

  task results;
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs;
    bus(0, SSIO_REG_CTRL, 0);
    chk(rdata, SSIO_CTRL_RESET);
    bus(0, 8'h0C, 0);
    chk(rdata, SSIO_RD_UNMAPPED);
    bus(1, SSIO_REG_CTRL, 32'h00000013);
    bus(0, SSIO_REG_CTRL, 0);
    chk({31'h0, param_mux_excl_bit2}, 32'h1);
    bus(1, SSIO_REG_CTRL, 32'h00000010);
    bus(0, SSIO_REG_CTRL, 0);
    chk({31'h0, param_mux_excl_bit2}, 32'h0);
    bus(1, SSIO_REG_CTRL, 32'h00000000);
  endtask : t_regs

  task automatic t_normal;
    bus(1, SSIO_REG_OWN, 32'h00000005);
    xchg(0, 5'h05, 4'h3, 1'b0);
    bus(0, SSIO_REG_STATUS, 0);
    chk(rdata[SSIO_ST_BLOCKED], 1);
    xchg(1, 5'h05, 4'h0, 1'b0);
    xchg(0, 5'h05, 4'h3, 1'b1);
    chk(resp_data, 4'hA);
    chk(out_pin, 4'h3);
  endtask : t_normal

  // Bank one is staged, then both banks land together.
  task automatic t_bank;
    bus(1, SSIO_REG_CTRL, 32'h0000000C);
    s0 = strobes;
    xchg(0, 5'h05, 4'h8, 1'b0);
    xchg(0, 5'h05, 4'h1, 1'b1);
    xchg(0, 5'h05, 4'h6, 1'b1);
    chk(out_pin, 4'h3);
    chk(strobes - s0, 0);
    xchg(0, 5'h05, 4'h1, 1'b1);
    chk(out_pin, 4'h6);
    repeat (2) @(posedge ref_clk);
    chk(strobes - s0, 1);
  endtask : t_bank

  task automatic t_sync;
    bus(1, SSIO_REG_CTRL, 32'h00000001);
    s0 = strobes;
    xchg(0, 5'h05, 4'h9, 1'b1);
    xchg(0, 5'h07, 4'h0, 1'b0);
    xchg(0, 5'h02, 4'h0, 1'b0);
    repeat (2) @(posedge ref_clk);
    chk(out_pin, 4'h9);
    chk(strobes - s0, 2);
    s0 = strobes;
    xchg(0, 5'h07, 4'h0, 1'b0);
    xchg(0, 5'h02, 4'h0, 1'b0);
    repeat (2) @(posedge ref_clk);
    chk(strobes - s0, 0);
  endtask : t_sync

  task automatic t_susp;
    repeat (3) xchg(0, 5'h05, 4'h2, 1'b1);
    bus(0, SSIO_REG_STATUS, 0);
    chk(rdata[SSIO_ST_SUSPENDED], 1);
    xchg(0, 5'h07, 4'h0, 1'b0);
    bus(0, SSIO_REG_STATUS, 0);
    chk(rdata[SSIO_ST_SUSPENDED], 0);
  endtask : t_susp

  // Lowest address: trigger calls answer fresh inputs, outputs lag one cycle.
  task automatic t_low;
    bus(1, SSIO_REG_OWN, 32'h00000001);
    data_in <= 4'h5;
    xchg(0, 5'h03, 4'h0, 1'b0);
    xchg(0, 5'h01, 4'h4, 1'b1);
    chk(resp_data, 4'h5);
    data_in <= 4'hC;
    xchg(0, 5'h03, 4'h0, 1'b0);
    xchg(0, 5'h01, 4'h6, 1'b1);
    chk(resp_data, 4'hC);
    chk(out_pin, 4'h4);
    xchg(0, 5'h03, 4'h0, 1'b0);
    xchg(0, 5'h01, 4'h7, 1'b1);
    chk(out_pin, 4'h6);
  endtask : t_low

  // A hang counts as a mismatch and ends in the closing report.
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    results();
  end

  // Main sequence.
  initial begin
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    data_in         = 4'hA;
    param_port_bit2 = 1'b0;
    rst             = 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_normal();
    t_bank();
    t_sync();
    t_susp();
    t_low();
    results();
  end
endmodule : tb_top
